// >>> rtl/mac_event_irq_aggregator.sv
/*
 Aggregates the MAC's event conditions into one controller-level request
 and models the vectored controller's handling of it: mask, group,
 sub-priority, natural order against one competing source, vector address.
 Assumes event conditions and software writes arrive on the system clock.
*/
// Operation
// - Eleven events merge into one request flag and mask at bit 28.
// - Request flag sets from merged condition whatever the mask; readable.
// - Mask clear raises no CPU interrupt; mask set raises one by priority.
// - Three-bit group 7 highest to 0; group 0 never interrupts.
// - Other source's service is preempted only by a strictly higher group MAC request; MAC service is never preempted.
// - Two-bit sub-priority 3 highest to 0 orders sources within a group.
// - Same group higher sub-priority waits until current service ends.
// - Equal group and sub-priority: lowest vector number wins.
// - Passed-over requests stay pending and are granted after the current service ends.
// - MAC request uses vector 48 and request number 60.
// - Vector address from exception base and spacing setting.
// - Transceiver interrupt goes to a separate external input.
// - Each event contributes only when enabled; status always readable.
// - Merged request stays high while any enabled event pends.
// - Group in bits 4:2 and sub-priority in bits 1:0.
`timescale 1ns/1ps
`include "mac_irq_map.svh"
module mac_event_irq_aggregator (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Event conditions from the MAC and software event writes.
   input wire mac_irq_pkg::evt_vec_t i_evt_set,
   input wire mac_irq_pkg::evt_vec_t i_evt_hw_level,
   input wire mac_irq_pkg::evt_vec_t i_evt_clr,
   input wire logic i_evt_en_we,
   input wire mac_irq_pkg::evt_vec_t i_evt_en_wdata,
   // Controller-level flag, mask and priority.
   input wire logic i_flag_clr,
   input wire logic i_mask_we,
   input wire logic i_mask_wdata,
   input wire logic i_prio_we,
   input wire logic [`PRIO_W-1:0] i_prio_wdata,
   input wire logic [4:0] i_vector_spacing,
   // Competing source seen by the controller.
   input wire mac_irq_pkg::req_s i_other_req,
   input wire logic i_other_done,
   // Transceiver interrupt pin, external path.
   input wire logic i_phy_irq_pin,
   // Status and CPU side.
   output mac_irq_pkg::evt_vec_t o_event_request_reg,
   output mac_irq_pkg::evt_vec_t o_event_enable_reg,
   output logic [31:0] o_irq_flag_reg_1,
   output logic [31:0] o_irq_enable_reg_1,
   output logic [31:0] o_irq_priority_reg_12,
   output logic o_cpu_irq,
   output logic [5:0] o_cpu_vector,
   output logic [6:0] o_irq_number,
   output logic [31:0] o_vector_addr,
   output logic o_mac_in_service,
   output logic o_ext_phy_irq
);
   import mac_irq_pkg::*;

   function automatic logic [5:0] rank(input logic [2:0] g,
                                       input logic [1:0] s);
      rank = {1'b0, g, s};
   endfunction

   function automatic logic [31:0] vec_addr(input logic [4:0] vs);
      case (vs)
         `VS_01: vec_addr = `VEC_BASE + `VEC_OFF_VS01;
         `VS_02: vec_addr = `VEC_BASE + `VEC_OFF_VS02;
         `VS_04: vec_addr = `VEC_BASE + `VEC_OFF_VS04;
         `VS_08: vec_addr = `VEC_BASE + `VEC_OFF_VS08;
         `VS_10: vec_addr = `VEC_BASE + `VEC_OFF_VS10;
         default: vec_addr = `VEC_BASE + `VEC_OFF_VS01;
      endcase
   endfunction

   evt_vec_t evt_reg, evt_next, en_reg, en_next;
   logic flag_reg, flag_next, mask_reg, mask_next;
   prio_s prio_reg, prio_next;
   svc_e st_reg, st_next;
   logic irq_reg, irq_next;
   logic [31:0] addr_reg, addr_next;
   logic [5:0] vec_reg, vec_next;
   logic [2:0] nest_grp_reg, nest_grp_next;
   logic in_service_reg, in_service_next;
   logic phy_s1_reg, phy_s2_reg, phy_reg;
   logic merged, mac_cand, other_cand, mac_wins;

   // Events and merge.
   always_comb begin
      // Software-clearable bits latch; watermark and pending bits follow level.
      evt_next = ((evt_reg & ~i_evt_clr) | i_evt_set) & `EVT_SWCLR_MASK;
      evt_next = evt_next | (i_evt_hw_level & ~`EVT_SWCLR_MASK
                             & `EVT_IMPL_MASK);
      en_next = i_evt_en_we ? (i_evt_en_wdata & `EVT_IMPL_MASK) : en_reg;
      merged = |(evt_reg & en_reg);
      // Set wins over a clear in the same cycle.
      flag_next = merged | (flag_reg & ~i_flag_clr);
      mask_next = i_mask_we ? i_mask_wdata : mask_reg;
      prio_next = i_prio_we ? prio_s'(i_prio_wdata) : prio_reg;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         evt_reg <= `EVT_RESET;
         en_reg <= `EVT_RESET;
         flag_reg <= 1'b0;
         mask_reg <= 1'b0;
         prio_reg <= prio_s'(`PRIO_RESET);
      end else begin
         evt_reg <= evt_next;
         en_reg <= en_next;
         flag_reg <= flag_next;
         mask_reg <= mask_next;
         prio_reg <= prio_next;
      end
   end

   // Arbitration against the competing source.
   always_comb begin
      mac_cand = flag_reg && mask_reg && (prio_reg.grp != `GRP_NONE);
      other_cand = i_other_req.valid && (i_other_req.grp != `GRP_NONE);
      // Ties go to the lower vector number.
      if (!other_cand) begin
         mac_wins = mac_cand;
      end else if (rank(prio_reg.grp, prio_reg.sub)
                   != rank(i_other_req.grp, i_other_req.sub)) begin
         mac_wins = mac_cand && (rank(prio_reg.grp, prio_reg.sub)
                    > rank(i_other_req.grp, i_other_req.sub));
      end else begin
         mac_wins = mac_cand && (`MAC_VECTOR < i_other_req.vector);
      end
      st_next = st_reg;
      irq_next = 1'b0;
      vec_next = vec_reg;
      addr_next = addr_reg;
      nest_grp_next = nest_grp_reg;
      case (st_reg)
         ST_IDLE: begin
            // A passed-over request stays and is granted later.
            if (mac_wins) begin
               st_next = ST_SERVE;
               irq_next = 1'b1;
               vec_next = `MAC_VECTOR;
               addr_next = vec_addr(i_vector_spacing);
            end else if (other_cand) begin
               st_next = ST_NEST;
               irq_next = 1'b1;
               vec_next = i_other_req.vector;
               addr_next = `VEC_BASE;
               nest_grp_next = i_other_req.grp;
            end
         end
         ST_SERVE: begin
            if (i_flag_clr && !merged) begin
               st_next = ST_IDLE;
            end
         end
         ST_NEST: begin
            // Only a strictly higher group preempts.
            // The group is the one captured at entry, because the other
            // source may withdraw its request while still in service.
            if (mac_cand && prio_reg.grp > nest_grp_reg) begin
               st_next = ST_SERVE;
               irq_next = 1'b1;
               vec_next = `MAC_VECTOR;
               addr_next = vec_addr(i_vector_spacing);
            end else if (i_other_done) begin
               st_next = ST_IDLE;
            end
         end
         default: st_next = ST_IDLE;
      endcase
      in_service_next = (st_next == ST_SERVE);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_reg <= ST_IDLE;
         irq_reg <= 1'b0;
         vec_reg <= '0;
         addr_reg <= '0;
         nest_grp_reg <= `GRP_NONE;
         in_service_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         irq_reg <= irq_next;
         vec_reg <= vec_next;
         addr_reg <= addr_next;
         nest_grp_reg <= nest_grp_next;
         in_service_reg <= in_service_next;
      end
   end

   // Transceiver pin bypasses the event logic.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         phy_s1_reg <= 1'b0;
         phy_s2_reg <= 1'b0;
         phy_reg <= 1'b0;
      end else begin
         phy_s1_reg <= i_phy_irq_pin;
         phy_s2_reg <= phy_s1_reg;
         phy_reg <= phy_s2_reg;
      end
   end

   assign o_event_request_reg = evt_reg;
   assign o_event_enable_reg = en_reg;
   assign o_irq_flag_reg_1 = 32'(flag_reg) << `MAC_FLAG_BIT;
   assign o_irq_enable_reg_1 = 32'(mask_reg) << `MAC_FLAG_BIT;
   assign o_irq_priority_reg_12 = 32'(prio_reg);
   assign o_cpu_irq = irq_reg;
   assign o_cpu_vector = vec_reg;
   assign o_irq_number = `MAC_IRQ_NUM;
   assign o_vector_addr = addr_reg;
   assign o_mac_in_service = in_service_reg;
   assign o_ext_phy_irq = phy_reg;

   AST_FLAG_SET: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      merged |=> flag_reg)
      else $error("flag not set by merged condition");
   AST_MASK_BLOCK: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      !mask_reg && st_reg == ST_IDLE
      |=> !(irq_reg && vec_reg == `MAC_VECTOR))
      else $error("masked request raised interrupt");
   AST_GRP_ZERO: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      prio_reg.grp == `GRP_NONE
      |=> st_reg != ST_SERVE || $past(st_reg) == ST_SERVE)
      else $error("group zero interrupted");
   AST_NO_AUTOCLR: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      flag_reg && !i_flag_clr |=> flag_reg)
      else $error("flag cleared without software");
   AST_MERGE: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      !flag_reg && (evt_reg & en_reg) == `EVT_RESET |=> !flag_reg)
      else $error("flag rose without an enabled event");
   AST_VEC48: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg == ST_IDLE && mac_wins
      |=> o_cpu_irq && o_cpu_vector == 6'h30)
      else $error("wrong vector");
   AST_ADDR: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg == ST_IDLE && mac_wins && i_vector_spacing == `VS_10
      |=> o_vector_addr == 32'h8000_6200)
      else $error("wrong vector address");
   AST_NO_SUBPREEMPT: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg == ST_NEST && prio_reg.grp <= nest_grp_reg
      |=> st_reg != ST_SERVE)
      else $error("same group preempted");
   AST_UNEN: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      en_reg == `EVT_RESET |-> !merged)
      else $error("disabled event merged");
   COV_SERVE: cover property (@(posedge i_ref_clk) st_reg == ST_SERVE);
   COV_PREEMPT: cover property (@(posedge i_ref_clk)
      st_reg == ST_NEST ##1 st_reg == ST_SERVE);
   COV_TIE: cover property (@(posedge i_ref_clk) mac_cand && other_cand
      && prio_reg == {i_other_req.grp, i_other_req.sub});
endmodule

// >>> rtl/mac_irq_map.svh
/*
 Constants for the MAC event interrupt aggregator: event bit positions,
 controller-level bit positions, priority fields, vector data.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef MAC_IRQ_MAP_SVH
`define MAC_IRQ_MAP_SVH
`define EVT_W 15
`define EVT_RX_OVERFLOW_EVT_BIT 0
`define EVT_RXNOBUF_BIT 1
`define EVT_TX_ABORTED_EVT_BIT 2
`define EVT_TX_COMPLETE_EVT_BIT 3
`define EVT_RX_ACTIVITY_EVT_BIT 5
`define EVT_PKTWAIT_BIT 6
`define EVT_RX_COMPLETE_EVT_BIT 7
`define EVT_FULLWM_BIT 8
`define EVT_EMPTYWM_BIT 9
`define EVT_RX_BUS_ERROR_EVT_BIT 13
`define EVT_TX_BUS_ERROR_EVT_BIT 14
`define EVT_IMPL_MASK 15'h63EF
`define EVT_SWCLR_MASK 15'h60AF
`define EVT_RESET 15'h0000
`define MAC_FLAG_BIT 28
`define PRIO_W 5
`define GRP_MSB 4
`define GRP_LSB 2
`define SUB_MSB 1
`define SUB_LSB 0
`define GRP_NONE 3'h0
`define PRIO_RESET 5'h00
`define MAC_VECTOR 6'h30
`define MAC_IRQ_NUM 7'h3C
`define VEC_BASE 32'h8000_0000
`define VEC_OFF_VS01 32'h0000_0800
`define VEC_OFF_VS02 32'h0000_0E00
`define VEC_OFF_VS04 32'h0000_1A00
`define VEC_OFF_VS08 32'h0000_3200
`define VEC_OFF_VS10 32'h0000_6200
`define VS_01 5'h01
`define VS_02 5'h02
`define VS_04 5'h04
`define VS_08 5'h08
`define VS_10 5'h10
`endif

// >>> rtl/mac_irq_pkg.sv
/*
 Types for the MAC event interrupt aggregator.
 Assumes the constant map header is on the include path.
*/
`include "mac_irq_map.svh"
package mac_irq_pkg;
   typedef logic [`EVT_W-1:0] evt_vec_t;
   typedef struct packed {
      logic [2:0] grp;
      logic [1:0] sub;
   } prio_s;
   typedef struct packed {
      logic valid;
      logic [2:0] grp;
      logic [1:0] sub;
      logic [5:0] vector;
   } req_s;
   typedef enum logic [1:0] {ST_IDLE, ST_SERVE, ST_NEST} svc_e;
endpackage

// >>> dv/irq_service_model.sv
/*
 Service routine model for the MAC interrupt: clears events, then the flag.
 Assumes it is told of every CPU grant and waits a bench-chosen delay.
*/
`timescale 1ns/1ps
`include "mac_irq_map.svh"
module irq_service_model (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Grant from the controller and service latency.
   input wire logic i_cpu_irq,
   input wire logic [5:0] i_cpu_vector,
   input wire logic [2:0] i_delay,
   // Software clears.
   output mac_irq_pkg::evt_vec_t o_evt_clr,
   output logic o_flag_clr
);
   initial begin
      o_evt_clr = '0;
      o_flag_clr = 1'b0;
      forever begin
         @(negedge i_ref_clk);
         if (!i_rst && i_cpu_irq === 1'b1 && i_cpu_vector === `MAC_VECTOR) begin
            repeat (i_delay) @(negedge i_ref_clk);
            o_evt_clr = `EVT_SWCLR_MASK;
            @(negedge i_ref_clk);
            o_evt_clr = '0;
            o_flag_clr = 1'b1;
            @(negedge i_ref_clk);
            o_flag_clr = 1'b0;
         end
      end
   end
endmodule

// >>> dv/testbench.sv
/*
 Self-checking bench for the MAC event interrupt aggregator.
 Assumes the service model clears flags after each MAC grant.
*/
`timescale 1ns/1ps
`include "mac_irq_map.svh"
module testbench;
   import mac_irq_pkg::*;
   logic clk = 0, rst = 1, en_we = 0, mask_we = 0, mask_wd = 0, prio_we = 0;
   logic flag_clr, other_done = 0, phy = 0, irq, busy, ext;
   logic [4:0] prio_wd = '0, vs = `VS_01;
   logic [2:0] dly = '0;
   evt_vec_t set = '0, hw = '0, clr, en_wd = '0, ereq, een;
   req_s other = '0;
   logic [31:0] flag, ien, prio, addr;
   logic [5:0] vec;
   logic [6:0] num;
   logic [37:0] exp_q[$];
   int bad_count = 0, checked = 0, seed = 28, i, b;
   int swb[8] = '{0, 1, 2, 3, 5, 7, 13, 14};
   logic [4:0] vst[5] = '{`VS_01, `VS_02, `VS_04, `VS_08, `VS_10};
   logic [31:0] off[5] = '{`VEC_OFF_VS01, `VEC_OFF_VS02, `VEC_OFF_VS04,
      `VEC_OFF_VS08, `VEC_OFF_VS10};
   mac_event_irq_aggregator dut (.i_ref_clk(clk), .i_rst(rst),
      .i_evt_set(set), .i_evt_hw_level(hw), .i_evt_clr(clr),
      .i_evt_en_we(en_we), .i_evt_en_wdata(en_wd), .i_flag_clr(flag_clr),
      .i_mask_we(mask_we), .i_mask_wdata(mask_wd), .i_prio_we(prio_we),
      .i_prio_wdata(prio_wd), .i_vector_spacing(vs), .i_other_req(other),
      .i_other_done(other_done), .i_phy_irq_pin(phy),
      .o_event_request_reg(ereq), .o_event_enable_reg(een),
      .o_irq_flag_reg_1(flag), .o_irq_enable_reg_1(ien),
      .o_irq_priority_reg_12(prio), .o_cpu_irq(irq), .o_cpu_vector(vec),
      .o_irq_number(num), .o_vector_addr(addr), .o_mac_in_service(busy),
      .o_ext_phy_irq(ext));
   irq_service_model svc (.i_ref_clk(clk), .i_rst(rst), .i_cpu_irq(irq),
      .i_cpu_vector(vec), .i_delay(dly), .o_evt_clr(clr),
      .o_flag_clr(flag_clr));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input int k, input logic [14:0] d);
      case (k)
         0: begin
            en_we = 1;
            en_wd = d;
         end
         1: begin
            mask_we = 1;
            mask_wd = d[0];
         end
         default: begin
            prio_we = 1;
            prio_wd = d[4:0];
         end
      endcase
      @(negedge clk);
      en_we = 0;
      mask_we = 0;
      prio_we = 0;
   endtask
   task automatic fire();
      b = swb[$unsigned($random(seed)) % 8];
      set = evt_vec_t'(1) << b;
      @(negedge clk);
      set = '0;
   endtask
   task automatic wait_idle();
      int n;
      for (n = 0; n < 300 && (exp_q.size() != 0 || flag[28] !== 1'b0); n++)
         @(negedge clk);
      if (n == 300) begin
         bad_count++;
         final_report();
      end
   endtask
   task automatic wait_vec(input logic [5:0] v);
      int n;
      for (n = 0; n < 100 && !(irq === 1'b1 && vec === v); n++)
         @(negedge clk);
      if (n == 100) begin
         bad_count++;
         final_report();
      end
   endtask
   // Every grant must match the oldest expectation; unexpected ones fail.
   always @(negedge clk) begin
      if (irq === 1'b1) begin
         if (exp_q.size() == 0) chk(1, 0);
         else chk({vec, addr}, exp_q.pop_front());
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      rst = 0;
      chk(num, 7'h3C);
      chk(flag, 0);
      wr(0, `EVT_IMPL_MASK);
      chk(een, `EVT_IMPL_MASK);
      wr(1, 1);
      wr(2, 5'h16);
      chk(prio, 32'h16);
      chk(ien, 32'h1 << `MAC_FLAG_BIT);
      for (i = 0; i < 5; i++) begin
         vs = vst[i];
         dly = 3'($random(seed));
         exp_q.push_back({`MAC_VECTOR, `VEC_BASE + off[i]});
         fire();
         wait_idle();
         chk(ereq, '0);
      end
      exp_q.push_back({`MAC_VECTOR, `VEC_BASE + off[4]});
      fire();
      @(negedge clk);
      fire();
      wait_idle();
      wr(1, 0);
      fire();
      repeat (6) @(negedge clk);
      chk(flag, 32'h1 << `MAC_FLAG_BIT);
      exp_q.push_back({`MAC_VECTOR, `VEC_BASE + off[4]});
      wr(1, 1);
      wait_idle();
      wr(2, 5'h03);
      fire();
      repeat (6) @(negedge clk);
      exp_q.push_back({`MAC_VECTOR, `VEC_BASE + off[4]});
      wr(2, 5'h04);
      wait_idle();
      wr(0, 15'h62EF);
      chk(een, 15'h62EF);
      hw[`EVT_FULLWM_BIT] = 1;
      repeat (4) @(negedge clk);
      chk(ereq[`EVT_FULLWM_BIT], 1);
      chk(flag, 0);
      hw = '0;
      wr(0, `EVT_IMPL_MASK);
      wr(2, 5'h16);
      @(negedge clk);
      for (i = 0; i < 2; i++) begin
         wr(2, 5'h03);
         fire();
         repeat (5) @(negedge clk);
         if (i == 0) exp_q.push_back({6'h20, `VEC_BASE});
         exp_q.push_back({`MAC_VECTOR, `VEC_BASE + off[4]});
         if (i == 1) exp_q.push_back({6'h38, `VEC_BASE});
         wr(2, 5'h16);
         other = '{1'b1, 3'h5, 2'h2, i ? 6'h38 : 6'h20};
         wait_vec(other.vector);
         other = '0;
         other_done = 1;
         @(negedge clk);
         other_done = 0;
         wait_idle();
      end
      // Other source in service: same group waits, higher group preempts.
      wr(2, 5'h03);
      fire();
      repeat (5) @(negedge clk);
      exp_q.push_back({6'h20, `VEC_BASE});
      other = '{1'b1, 3'h5, 2'h1, 6'h20};
      wait_vec(6'h20);
      wr(2, 5'h17);
      repeat (4) @(negedge clk);
      chk(busy, 0);
      exp_q.push_back({`MAC_VECTOR, `VEC_BASE + off[4]});
      wr(2, 5'h1A);
      wait_vec(`MAC_VECTOR);
      chk(busy, 1);
      other = '0;
      other_done = 1;
      @(negedge clk);
      other_done = 0;
      wait_idle();
      phy = 1;
      repeat (4) @(negedge clk);
      chk(ext, 1);
      phy = 0;
      repeat (4) @(negedge clk);
      chk(ext, 0);
      final_report();
   end
endmodule
